// ==== design/ccp_timer_select_and_capture.v ====
// Timer routing, open-drain control and capture logic for channels 4 to 10
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/100ps
`include "ccp_defs.vh"
module ccp_timer_select_and_capture (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  timer_one,
  timer_three,
  timer_five,
  timer_two,
  timer_four,
  timer_six,
  timer_eight,
  pwm_level,
  channel_pin_in,
  channel_pin_out,
  channel_pin_oe,
  cc_timer_value,
  pwm_timer_value,
  event_flag_reg,
  event_enable_reg
);
  input          pclk;
  input          presetn;
  input          psel;
  input          penable;
  input          pwrite;
  input  [11:0]  paddr;
  input  [31:0]  pwdata;
  output [31:0]  prdata;
  output         pready;
  output         pslverr;
  input  [15:0]  timer_one;
  input  [15:0]  timer_three;
  input  [15:0]  timer_five;
  input  [7:0]   timer_two;
  input  [7:0]   timer_four;
  input  [7:0]   timer_six;
  input  [7:0]   timer_eight;
  input  [6:0]   pwm_level;
  input  [6:0]   channel_pin_in;
  output [6:0]   channel_pin_out;
  output [6:0]   channel_pin_oe;
  output [111:0] cc_timer_value;
  output [55:0]  pwm_timer_value;
  output [6:0]   event_flag_reg;
  output [6:0]   event_enable_reg;

  reg  [31:0]  prdata;
  reg          pready;
  reg          pslverr;
  reg  [6:0]   channel_pin_out;
  reg  [6:0]   channel_pin_oe;
  reg  [111:0] cc_timer_value;
  reg  [55:0]  pwm_timer_value;
  reg  [6:0]   event_flag_reg;
  reg  [6:0]   event_enable_reg;
  reg  [7:0]   timer_route_reg_a;
  reg  [7:0]   timer_route_reg_b;
  reg  [7:0]   open_drain_reg_a;
  reg  [7:0]   open_drain_reg_b;
  reg  [6:0]   port_latch_r;
  reg  [6:0]   pin_dir_r;
  reg  [5:0]   channel_control [0:6];
  reg  [6:0]   sync1_r;
  reg  [6:0]   sync2_r;
  reg  [6:0]   prev_r;
  reg  [3:0]   presc_r [0:6];
  reg  [6:0]   cap_evt;
  reg  [6:0]   latch_wr_evt;
  reg  [111:0] cc_sel_nxt;
  reg  [55:0]  pwm_sel_nxt;
  reg          rd_pend_r;
  reg  [31:0]  rd_word;
  reg          rd_err;
  wire [15:0]  cap_rd;
  wire         apb_setup;
  wire         wr_go;
  wire [2:0]   rd_idx;
  wire [6:0]   rise;
  wire [6:0]   fall;
  wire [6:0]   open_drain_sel;
  integer      i;
  integer      j;
  integer      n;
  integer      q;

  // Output mode: compare (1000-1011, 0010) or PWM (11xx)
  function is_output_mode;
    input [3:0] m;
    begin
      is_output_mode = m[3] | (m == 4'h2);
    end
  endfunction

  function is_capture_mode;
    input [3:0] m;
    begin
      is_capture_mode = (m[3:2] == 2'b01);
    end
  endfunction

  // Capture/compare timer choice for a channel
  function [15:0] cc_pick;
    input [2:0]  ch;
    input [7:0]  ra;
    input [15:0] t1;
    input [15:0] t3;
    input [15:0] t5;
    begin
      case (ch)
        3'd0:    cc_pick = (ra[1:0] == 2'b00) ? t1 : t3;
        3'd1:    cc_pick = ra[2] ? t5 : t1;
        3'd2:    cc_pick = ra[4] ? t5 : t1;
        3'd3:    cc_pick = (ra[7:6] == 2'b00) ? t1 : t5;
        default: cc_pick = t1;
      endcase
    end
  endfunction

  function [7:0] even_pick;
    input [1:0] s;
    input [7:0] t2;
    input [7:0] t4;
    input [7:0] t6;
    input [7:0] t8;
    begin
      case (s)
        2'b00:   even_pick = t2;
        2'b01:   even_pick = t4;
        2'b10:   even_pick = t6;
        default: even_pick = t8;
      endcase
    end
  endfunction

  assign apb_setup = psel & ~penable;
  assign wr_go = psel & penable & pwrite & pready;
  assign rd_idx = paddr[4:2];
  assign open_drain_sel = {open_drain_reg_b[3:2], open_drain_reg_a[4:0]};
  assign rise = sync2_r & ~prev_r;
  assign fall = ~sync2_r & prev_r;

  // Timer routing; reserved codes fall back to a defined choice
  always @* begin
    cc_sel_nxt = 112'h0;
    pwm_sel_nxt = 56'h0;
    for (i = 0; i < 7; i = i + 1) begin
      cc_sel_nxt[i*16 +: 16] = cc_pick(i[2:0], timer_route_reg_a,
                                       timer_one, timer_three, timer_five);
    end
    pwm_sel_nxt[7:0]   = even_pick(timer_route_reg_a[1:0], timer_two,
                                   timer_four, timer_six, timer_two);
    pwm_sel_nxt[15:8]  = timer_route_reg_a[2] ? timer_four : timer_two;
    pwm_sel_nxt[23:16] = timer_two;
    pwm_sel_nxt[31:24] = even_pick(timer_route_reg_a[7:6], timer_two,
                                   timer_four, timer_six, timer_eight);
    pwm_sel_nxt[39:32] = even_pick(timer_route_reg_b[1:0], timer_two,
                                   timer_four, timer_six, timer_two);
    pwm_sel_nxt[47:40] = timer_route_reg_b[2] ? timer_four : timer_two;
    pwm_sel_nxt[55:48] = timer_two;
  end

  // Capture event per channel
  always @* begin
    cap_evt = 7'h00;
    for (j = 0; j < 7; j = j + 1) begin
      case (channel_control[j][3:0])
        `MODE_FALL:   cap_evt[j] = fall[j] | latch_wr_evt[j];
        `MODE_RISE:   cap_evt[j] = rise[j] | latch_wr_evt[j];
        `MODE_RISE4:  cap_evt[j] = (rise[j] | latch_wr_evt[j]) & (presc_r[j][1:0] == 2'h3);
        `MODE_RISE16: cap_evt[j] = (rise[j] | latch_wr_evt[j]) & (presc_r[j] == 4'hf);
        default:      cap_evt[i] = 1'b0;
      endcase
    end
  end

  // A port latch write that changes the bit of an output-direction pin counts as an edge
  always @* begin
    latch_wr_evt = 7'h00;
    for (n = 0; n < 7; n = n + 1) begin
      latch_wr_evt[n] = wr_go & (paddr == `OFF_PORT_LATCH) & ~pin_dir_r[n]
                        & (pwdata[n] != port_latch_r[n]);
    end
  end

  always @* begin
    rd_word = 32'h0;
    rd_err = 1'b0;
    case (paddr)
      `OFF_ROUTE_A:    rd_word = {24'h0, timer_route_reg_a};
      `OFF_ROUTE_B:    rd_word = {24'h0, timer_route_reg_b};
      `OFF_OD_A:       rd_word = {24'h0, open_drain_reg_a};
      `OFF_OD_B:       rd_word = {24'h0, open_drain_reg_b};
      `OFF_FLAGS:      rd_word = {24'h0, event_flag_reg, 1'b0};
      `OFF_IRQ_EN:     rd_word = {24'h0, event_enable_reg, 1'b0};
      `OFF_PORT_LATCH: rd_word = {25'h0, port_latch_r};
      `OFF_DIR:        rd_word = {25'h0, pin_dir_r};
      default: begin
        if (paddr[11:5] == 7'h02 && rd_idx < 3'h7) begin
          rd_word = {26'h0, channel_control[rd_idx]};
        end else if (paddr[11:5] == 7'h04 && rd_idx < 3'h7) begin
          rd_word = {16'h0, cap_rd};
        end else begin
          rd_err = 1'b1;
        end
      end
    endcase
  end

  capture_store u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (cap_evt),
    .wr_idx  (3'h0),
    .wr_data (cc_timer_value),
    .rd_idx  (rd_idx),
    .rd_data (cap_rd)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rd_pend_r <= 1'b0;
      timer_route_reg_a <= `RST_BYTE;
      timer_route_reg_b <= `RST_BYTE;
      open_drain_reg_a <= `RST_BYTE;
      open_drain_reg_b <= `RST_BYTE;
      event_flag_reg <= 7'h00;
      event_enable_reg <= 7'h00;
      port_latch_r <= 7'h00;
      pin_dir_r <= `RST_DIR;
      sync1_r <= 7'h00;
      sync2_r <= 7'h00;
      prev_r <= 7'h00;
      channel_pin_out <= 7'h00;
      channel_pin_oe <= 7'h00;
      cc_timer_value <= 112'h0;
      pwm_timer_value <= 56'h0;
      for (q = 0; q < 7; q = q + 1) begin
        channel_control[q] <= 6'h00;
        presc_r[q] <= 4'h0;
      end
    end else begin
      // Writes answer in the first access cycle; reads wait one more cycle
      // because the capture memory output is registered
      pready <= (apb_setup & pwrite) | rd_pend_r;
      pslverr <= ((apb_setup & pwrite) | rd_pend_r) & rd_err;
      rd_pend_r <= apb_setup & ~pwrite;
      if (rd_pend_r) begin
        prdata <= rd_word;
      end
      sync1_r <= channel_pin_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      cc_timer_value <= cc_sel_nxt;
      pwm_timer_value <= pwm_sel_nxt;
      for (q = 0; q < 7; q = q + 1) begin
        if (!is_capture_mode(channel_control[q][3:0])) begin
          presc_r[q] <= 4'h0;
        end else if (rise[q] | latch_wr_evt[q]) begin
          presc_r[q] <= presc_r[q] + 4'h1;
        end
        channel_oe_drive(q);
      end
      if (wr_go) begin
        case (paddr)
          `OFF_ROUTE_A:    timer_route_reg_a <= pwdata[7:0] & `ROUTE_A_MASK;
          `OFF_ROUTE_B:    timer_route_reg_b <= pwdata[7:0] & `ROUTE_B_MASK;
          `OFF_OD_A:       open_drain_reg_a <= pwdata[7:0] & `OD_A_MASK;
          `OFF_OD_B:       open_drain_reg_b <= pwdata[7:0] & `OD_B_MASK;
          `OFF_IRQ_EN:     event_enable_reg <= pwdata[7:1];
          `OFF_PORT_LATCH: port_latch_r <= pwdata[6:0];
          `OFF_DIR:        pin_dir_r <= pwdata[6:0];
          default: begin
            if (paddr[11:5] == 7'h02 && rd_idx < 3'h7) begin
              channel_control[rd_idx] <= pwdata[5:0];
            end
          end
        endcase
      end
      // Write-one-to-clear; a capture in the same cycle wins
      if (wr_go && paddr == `OFF_FLAGS) begin
        event_flag_reg <= (event_flag_reg & ~pwdata[7:1]) | cap_evt;
      end else begin
        event_flag_reg <= event_flag_reg | cap_evt;
      end
    end
  end

  // Pin driver: open-drain in output modes only releases instead of driving high
  task channel_oe_drive;
    input integer k;
    reg lvl;
    begin
      lvl = channel_control[k][3] & channel_control[k][2] ? pwm_level[k] : port_latch_r[k];
      if (pin_dir_r[k]) begin
        channel_pin_oe[k] <= 1'b0;
        channel_pin_out[k] <= 1'b0;
      end else if (open_drain_sel[k] && is_output_mode(channel_control[k][3:0])) begin
        channel_pin_oe[k] <= ~lvl;
        channel_pin_out[k] <= 1'b0;
      end else begin
        channel_pin_oe[k] <= 1'b1;
        channel_pin_out[k] <= lvl;
      end
    end
  endtask
endmodule // ccp_timer_select_and_capture

// ==== design/ccp_defs.vh ====
// Register offsets, field positions and reset values of the capture block
`ifndef CCP_DEFS_VH
`define CCP_DEFS_VH
`define OFF_ROUTE_A     12'h000
`define OFF_ROUTE_B     12'h004
`define OFF_OD_A        12'h008
`define OFF_OD_B        12'h00c
`define OFF_FLAGS       12'h010
`define OFF_IRQ_EN      12'h014
`define OFF_PORT_LATCH  12'h018
`define OFF_DIR         12'h01c
`define OFF_CTRL_BASE   12'h040
`define OFF_CAP_BASE    12'h080
`define ROUTE_A_MASK    8'hd7
`define ROUTE_B_MASK    8'h17
`define OD_A_MASK       8'hff
`define OD_B_MASK       8'h0c
`define CTRL_MASK       8'h3f
`define MODE_OFF        4'h0
`define MODE_FALL       4'h4
`define MODE_RISE       4'h5
`define MODE_RISE4      4'h6
`define MODE_RISE16     4'h7
`define FLAG_LSB        1
`define NUM_CH          7
`define RST_BYTE        8'h00
`define RST_DIR         7'h7f
`endif

// ==== design/capture_store.v ====
// Memory of seven 16-bit captured timer values with registered read port
`timescale 1ns/100ps
module capture_store (
  pclk,
  presetn,
  wr_en,
  wr_idx,
  wr_data,
  rd_idx,
  rd_data
);
  input         pclk;
  input         presetn;
  input  [6:0]  wr_en;
  input  [111:0] wr_data;
  input  [2:0]  wr_idx;
  input  [2:0]  rd_idx;
  output [15:0] rd_data;
  reg    [15:0] mem_r [0:6];
  reg    [15:0] rd_data;
  integer       i;
  // wr_idx unused: one write port per channel, all may capture in one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 7; i = i + 1) begin
        mem_r[i] <= 16'h0000;
      end
      rd_data <= 16'h0000;
    end else begin
      for (i = 0; i < 7; i = i + 1) begin
        if (wr_en[i]) begin
          mem_r[i] <= wr_data[i*16 +: 16];
        end
      end
      if (rd_idx < 3'h7) begin
        rd_data <= mem_r[rd_idx];
      end else begin
        rd_data <= 16'h0000;
      end
    end
  end
endmodule // capture_store

// ==== tb/pin_source.sv ====
// Pulse source standing in for the signals on the capture pins
`timescale 1ns/100ps
module pin_source (
  input  wire logic       pclk,
  output logic      [6:0] pin
);
  // Idle pins rest low, as behind a pull-down
  initial pin = 7'h00;
  // Both levels are held w clocks so the synchroniser cannot miss one
  task pulse(input logic [6:0] m, input int w);
    @(posedge pclk);
    pin <= m;
    repeat (w) @(posedge pclk);
    pin <= 7'h00;
    repeat (w) @(posedge pclk);
  endtask
endmodule // pin_source

// ==== tb/ccp_timer_select_and_capture_monitor.sv ====
// Bus and routing assertions on the capture block ports
`timescale 1ns/100ps
`include "ccp_defs.vh"
module ccp_timer_select_and_capture_monitor (
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic [15:0]  timer_one,
  input wire logic [111:0] cc_timer_value,
  input wire logic [6:0]   event_flag_reg,
  input wire logic [6:0]   event_enable_reg
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence wr_setup;
    psel && !penable && pwrite;
  endsequence
  sequence rd_setup;
    psel && !penable && !pwrite;
  endsequence
  sequence rd_wait;
    psel && penable && !pready;
  endsequence
  sequence apb_done;
    psel && penable && pready;
  endsequence
  a_setup_answer: assert property (wr_setup |=> apb_done)
    else $error("no answer after write setup");
  a_read_answer: assert property (rd_setup |=> rd_wait ##1 apb_done)
    else $error("no answer after read setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  // Only a software write may clear a flag
  a_flag_sticky: assert property ((|($past(event_flag_reg) & ~event_flag_reg)) |->
    $past(psel && penable && pready && pwrite && paddr == `OFF_FLAGS))
    else $error("flag cleared without write");
  a_enable_write: assert property (!$stable(event_enable_reg) |->
    $past(psel && penable && pready && pwrite && paddr == `OFF_IRQ_EN))
    else $error("enable changed without write");
  a_timer_one_route: assert property ($past(presetn) |->
    cc_timer_value[111:64] == {3{$past(timer_one)}})
    else $error("channels 8 to 10 not on timer one");
endmodule // ccp_timer_select_and_capture_monitor

// ==== tb/ccp_timer_select_and_capture_tb.sv ====
// Self-checking bench for timer routing, open drain and capture
`timescale 1ns/100ps
`include "ccp_defs.vh"
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED %0t %s", $time, m); end end
module ccp_timer_select_and_capture_tb;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err, exp_flag;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rdv;
  logic [15:0]  t1, t3, t5, exp_cap;
  logic [7:0]   t2, t4, t6, t8, ra;
  logic [6:0]   pwm_level, pin, pin_out, pin_oe, flags, enables;
  logic [111:0] ccv;
  logic [55:0]  pwmv;
  int           miscompares, checks, cycles, cnt, code[7];
  int           cci[7][4] = '{'{0,1,1,0}, '{0,2,0,0}, '{0,2,0,0}, '{0,2,2,2}, '{0,0,0,0}, '{0,0,0,0}, '{0,0,0,0}};
  int           pwi[7][4] = '{'{0,1,2,0}, '{0,1,0,0}, '{0,0,0,0}, '{0,1,2,3}, '{0,1,2,0}, '{0,1,0,0}, '{0,0,0,0}};

  ccp_timer_select_and_capture i_ccp_timer_select_and_capture (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_one(t1), .timer_three(t3), .timer_five(t5), .timer_two(t2), .timer_four(t4),
    .timer_six(t6), .timer_eight(t8), .pwm_level(pwm_level), .channel_pin_in(pin),
    .channel_pin_out(pin_out), .channel_pin_oe(pin_oe), .cc_timer_value(ccv),
    .pwm_timer_value(pwmv), .event_flag_reg(flags), .event_enable_reg(enables));
  pin_source i_pin_source (.pclk(pclk), .pin(pin));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Generous ceiling, the whole sequence needs about 1200 cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  task stop_test;
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One transfer, then an idle cycle so no signal is assigned twice in a step
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [15:0] cct(input int i);
    return (i == 0) ? t1 : (i == 1) ? t3 : t5;
  endfunction
  function automatic logic [7:0] pwt(input int i);
    return (i == 0) ? t2 : (i == 1) ? t4 : (i == 2) ? t6 : t8;
  endfunction

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pwm_level} = '0;
    {t1, t3, t5, t2, t4, t6, t8, exp_cap} = '0;
    void'($urandom(32'hee02e84d));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 'h9c; a += 4) begin
      apb(a[11:0], 1'b0, 32'h0);
      `CHK(err, !(a < 'h20 || (a >= 'h40 && a < 'h5c) || a >= 'h80), "slverr")
      `CHK(rdv, (a == 'h1c) ? 32'h7f : 32'h0, "reset value")
    end
    apb(`OFF_IRQ_EN, 1'b1, 32'hfc);
    `CHK(enables, 7'h7e, "enables")
    for (int k = 0; k < 4; k++) begin
      // Timers change only on the clock, as a synchronous timer would
      t1 <= $urandom;
      t3 <= $urandom;
      t5 <= $urandom;
      t2 <= $urandom;
      t4 <= $urandom;
      t6 <= $urandom;
      t8 <= $urandom;
      for (int c = 0; c < 7; c++)
        code[c] = (c == 3) ? k : (c == 6) ? 0 : (c == 0 || c == 4) ? k % 3 : k % 2;
      ra = {code[3][1:0], 1'b0, code[2][0], 1'b0, code[1][0], code[0][1:0]};
      apb(`OFF_ROUTE_A, 1'b1, {24'h0, ra});
      apb(`OFF_ROUTE_B, 1'b1, {29'h0, code[5][0], code[4][1:0]});
      apb(`OFF_ROUTE_A, 1'b0, 32'h0);
      `CHK(rdv[7:0], ra, "route readback")
      for (int c = 0; c < 7; c++) begin
        `CHK(ccv[16*c +: 16], cct(cci[c][code[c]]), "cc timer")
        `CHK(pwmv[8*c +: 8], pwt(pwi[c][code[c]]), "pwm timer")
      end
    end
    apb(`OFF_ROUTE_A, 1'b1, 32'h0);
    for (int m = 4; m < 8; m++) begin
      apb(`OFF_CTRL_BASE, 1'b1, 32'h0);
      apb(`OFF_CTRL_BASE, 1'b1, m);
      apb(`OFF_FLAGS, 1'b1, 32'h2);
      cnt = 0;
      exp_flag = 1'b0;
      for (int i = 0; i < 17; i++) begin
        t1 <= $urandom;
        i_pin_source.pulse(7'h01, 4);
        cnt++;
        if (m < 6 || (m == 6 && cnt % 4 == 0) || cnt % 16 == 0) begin
          exp_flag = 1'b1;
          exp_cap = t1;
        end
        `CHK(flags[0], exp_flag, "flag")
        apb(`OFF_CAP_BASE, 1'b0, 32'h0);
        `CHK(rdv, {16'h0, exp_cap}, "capture")
        if (i == 8) begin
          apb(`OFF_FLAGS, 1'b1, 32'h2);
          exp_flag = 1'b0;
        end
      end
    end
    apb(`OFF_CTRL_BASE, 1'b1, 32'hc);
    apb(`OFF_DIR, 1'b1, 32'h7e);
    for (int o = 0; o < 4; o++) begin
      apb(`OFF_OD_A, 1'b1, o >> 1);
      pwm_level <= {6'h0, o[0]};
      repeat (3) @(posedge pclk);
      `CHK(pin_oe[0], o != 3, "drive enable")
      `CHK(pin_oe[0] & pin_out[0], o == 1, "high drive")
    end
    apb(`OFF_CTRL_BASE, 1'b1, 32'h5);
    apb(`OFF_FLAGS, 1'b1, 32'h2);
    apb(`OFF_PORT_LATCH, 1'b1, 32'h1);
    repeat (4) @(posedge pclk);
    `CHK(flags[0], 1'b1, "latch capture")
    stop_test();
  end
endmodule // ccp_timer_select_and_capture_tb

bind ccp_timer_select_and_capture ccp_timer_select_and_capture_monitor i_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_one(timer_one), .cc_timer_value(cc_timer_value),
  .event_flag_reg(event_flag_reg), .event_enable_reg(event_enable_reg));
